// File: logic/sbod_defs.svh
`ifndef SBOD_DEFS_SVH
`define SBOD_DEFS_SVH

// instruction opcodes handled by this decoder
`define SBOD_OP_CNT_SEL 8'hce
`define SBOD_OP_CNT_START 8'h0f
`define SBOD_OP_CNT_STOP 8'h90
`define SBOD_OP_DEF_BYPASS 8'h07
// upper opcode bits of the indexed groups
`define SBOD_OP_PASS_HI 5'h14
`define SBOD_OP_DEDIO_HI 5'h16

// field positions inside an opcode
`define SBOD_IDX_MSB 2
`define SBOD_GRP_LSB 3

// reset values
`define SBOD_RST_DR_SEL 5'h01
`define SBOD_RST_IDX 3'h0
`define SBOD_RST_FLAG 1'h0

`endif

// File: logic/sbod_pkg.sv
package sbod_pkg;
  // data register placed between test data in and out, one-hot
  typedef enum logic [4:0] {
    SBOD_DR_IDCODE = 5'h01,
    SBOD_DR_BYPASS = 5'h02,
    SBOD_DR_COUNTER = 5'h04,
    SBOD_DR_PASS_EN = 5'h08,
    SBOD_DR_DED_IO = 5'h10
  } sbod_dr_t;
endpackage

// File: logic/sbod_decode.sv
`include "sbod_defs.svh"

// Function
// RULE1: opcode ce places the 32-bit test-clock counter register in the scan path.
// RULE2: opcode 0f (counter start) selects the identification register as data register.
// RULE3: opcode 90 (counter stop) selects the identification register as data register.
// RULE4: opcode 07 makes bypass the default data register for later data scans.
// RULE5: opcodes a0 to a7 select pass-through enable registers 0 to 7 by the low three bits.
// RULE6: opcodes b0 to b3 select dedicated io registers 0 to 3.
// RULE7: the selected data register is inserted into the scan chain only while the bridge is addressed.
module sbod_decode import sbod_pkg::*; #(
  parameter int PASS_COUNT = 8,
  parameter int DEDIO_COUNT = 4
) (
  // system clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // test clock domain, from the tap controller
  input wire logic tck_in,
  input wire logic [7:0] ir_opcode_in,
  input wire logic ir_update_in,
  input wire logic tap_reset_in,
  input wire logic bridge_sel_in,
  // test clock domain results
  output sbod_dr_t dr_sel_out,
  output logic [2:0] dr_index_out,
  output logic scan_insert_out,
  output logic counter_run_out,
  // system clock domain status
  output logic counter_run_sys_out,
  output logic default_bypass_sys_out
);

  ////////////////////////////////////////////////////////////////////////
  // parameter check, refused at elaboration
  // the index field is three bits, so the pass-through group holds eight
  // registers at the most; the dedicated io group here stops at four
  // a count below one would leave a group with no opcode at all
  if (PASS_COUNT < 1 || PASS_COUNT > 8 || DEDIO_COUNT < 1 || DEDIO_COUNT > 4) begin
    $error("sbod_decode: register counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // reset release in each domain
  logic sys_rst_meta_ff;
  logic sys_rst_n_ff;
  logic tck_rst_meta_ff;
  logic tck_rst_n_ff;

  // assertion is immediate; release waits two edges of the clock it feeds
  // system domain reset synchroniser
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_rst_meta_ff <= 1'b0;
      sys_rst_n_ff <= 1'b0;
    end else begin
      sys_rst_meta_ff <= 1'b1;
      sys_rst_n_ff <= sys_rst_meta_ff;
    end
  end

  // the test clock side stays in reset until tck has run two edges
  // test clock domain reset synchroniser
  always_ff @(posedge tck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tck_rst_meta_ff <= 1'b0;
      tck_rst_n_ff <= 1'b0;
    end else begin
      tck_rst_meta_ff <= 1'b1;
      tck_rst_n_ff <= tck_rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // opcode decode, test clock domain
  // instruction state is held until the next update or tap reset
  sbod_dr_t dr_sel_ff;
  sbod_dr_t nxt_dr_sel;
  logic [2:0] dr_index_ff;
  logic [2:0] nxt_dr_index;
  logic insert_ff;
  logic nxt_insert;
  logic counter_run_ff;
  logic nxt_counter_run;
  logic def_bypass_ff;
  logic nxt_def_bypass;
  logic [2:0] op_idx;
  logic [4:0] op_grp;

  // index field and group field of the opcode
  assign op_idx = ir_opcode_in[`SBOD_IDX_MSB:0];
  assign op_grp = ir_opcode_in[7:`SBOD_GRP_LSB];

  // opcode matches; the indexed groups also check the configured size
  // matched against the opcode as it stands at the update edge
  logic hit_cnt_sel;
  logic hit_cnt_start;
  logic hit_cnt_stop;
  logic hit_def_bypass;
  logic hit_pass_en;
  logic hit_ded_io;

  assign hit_cnt_sel = (ir_opcode_in == `SBOD_OP_CNT_SEL);
  assign hit_cnt_start = (ir_opcode_in == `SBOD_OP_CNT_START);
  assign hit_cnt_stop = (ir_opcode_in == `SBOD_OP_CNT_STOP);
  assign hit_def_bypass = (ir_opcode_in == `SBOD_OP_DEF_BYPASS);
  assign hit_pass_en = (op_grp == `SBOD_OP_PASS_HI) && (32'(op_idx) < PASS_COUNT); // [RULE5]
  assign hit_ded_io = (op_grp == `SBOD_OP_DEDIO_HI) && (32'(op_idx) < DEDIO_COUNT); // [RULE6]

  // next instruction state, taken on update-ir
  always_comb begin
    nxt_dr_sel = dr_sel_ff;
    nxt_dr_index = dr_index_ff;
    nxt_counter_run = counter_run_ff;
    nxt_def_bypass = def_bypass_ff;
    // selection follows every edge, not only instruction updates
    nxt_insert = bridge_sel_in; // [RULE7]
    if (tap_reset_in) begin
      // tap reset falls back to the identification register
      // the counter run level is kept across a tap reset
      nxt_dr_sel = sbod_dr_t'(`SBOD_RST_DR_SEL);
      nxt_dr_index = `SBOD_RST_IDX;
      nxt_def_bypass = `SBOD_RST_FLAG;
    end else if (ir_update_in) begin
      nxt_dr_index = `SBOD_RST_IDX;
      // index drops to zero unless an indexed group is selected
      if (hit_cnt_sel) begin
        // the 32-bit counter register goes into the path
        nxt_dr_sel = SBOD_DR_COUNTER; // [RULE1]
      end else if (hit_cnt_start) begin
        // start and stop only move the run level; the id register is scanned
        nxt_dr_sel = SBOD_DR_IDCODE; // [RULE2]
        nxt_counter_run = 1'b1; // [RULE2]
      end else if (hit_cnt_stop) begin
        nxt_dr_sel = SBOD_DR_IDCODE; // [RULE3]
        nxt_counter_run = 1'b0; // [RULE3]
      end else if (hit_def_bypass) begin
        // flag is sticky until a tap reset; bypass is taken at once as well
        nxt_dr_sel = SBOD_DR_BYPASS; // [RULE4]
        nxt_def_bypass = 1'b1; // [RULE4]
      end else if (hit_pass_en) begin
        // low three opcode bits name the register
        nxt_dr_sel = SBOD_DR_PASS_EN; // [RULE5]
        nxt_dr_index = op_idx; // [RULE5]
      end else if (hit_ded_io) begin
        nxt_dr_sel = SBOD_DR_DED_IO; // [RULE6]
        nxt_dr_index = op_idx; // [RULE6]
      end else begin
        // opcodes not handled here use the default register
        nxt_dr_sel = def_bypass_ff ? SBOD_DR_BYPASS : SBOD_DR_IDCODE; // [RULE4]
      end
    end
  end

  // test clock domain registers
  // reset values are those of a tap in test-logic-reset
  // results are registered on the update edge itself
  always_ff @(posedge tck_in or negedge tck_rst_n_ff) begin
    if (!tck_rst_n_ff) begin
      dr_sel_ff <= sbod_dr_t'(`SBOD_RST_DR_SEL);
      dr_index_ff <= `SBOD_RST_IDX;
      insert_ff <= `SBOD_RST_FLAG;
      counter_run_ff <= `SBOD_RST_FLAG;
      def_bypass_ff <= `SBOD_RST_FLAG;
    end else begin
      dr_sel_ff <= nxt_dr_sel;
      dr_index_ff <= nxt_dr_index;
      insert_ff <= nxt_insert;
      counter_run_ff <= nxt_counter_run;
      def_bypass_ff <= nxt_def_bypass;
    end
  end

  // outputs are the registers themselves, no logic after them,
  // so every result comes straight from a flop
  assign dr_sel_out = dr_sel_ff;
  assign dr_index_out = dr_index_ff;
  assign scan_insert_out = insert_ff;
  assign counter_run_out = counter_run_ff;

  ////////////////////////////////////////////////////////////////////////
  // levels into the system domain, two flops each
  // each bit is a slow level that settles long before it is read, so the
  // two bits may land one mclk apart; no word is carried across
  // a stopped tck freezes the levels where they stand
  logic [1:0] lvl_tck;
  logic [1:0] lvl_sys;

  assign lvl_tck = {def_bypass_ff, counter_run_ff};

  for (genvar b = 0; b < 2; b++) begin : g_lvl_sync
    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    // next values of one level synchroniser
    always_comb begin
      nxt_meta = lvl_tck[b];
      nxt_sync = meta_ff;
    end

    // system domain registers; only the second flop is read onward
    always_ff @(posedge mclk_in or negedge sys_rst_n_ff) begin
      if (!sys_rst_n_ff) begin
        meta_ff <= `SBOD_RST_FLAG;
        sync_ff <= `SBOD_RST_FLAG;
      end else begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
      end
    end

    assign lvl_sys[b] = sync_ff;
  end

  assign counter_run_sys_out = lvl_sys[0];
  assign default_bypass_sys_out = lvl_sys[1];

endmodule

// File: testbench/sbod_decode_monitor.sv
module sbod_decode_monitor import sbod_pkg::*; (
  // watched ports
  input wire logic tck_in,
  input wire logic rst_n_in,
  input wire logic [7:0] ir_opcode_in,
  input wire logic ir_update_in,
  input wire logic tap_reset_in,
  input wire logic bridge_sel_in,
  input wire sbod_dr_t dr_sel_out,
  input wire logic [2:0] dr_index_out,
  input wire logic scan_insert_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge tck_in); endclocking
  default disable iff (!rst_n_in);
  // an accepted update and its opcode
  wire logic t = ir_update_in && !tap_reset_in;
  wire logic [7:0] o = ir_opcode_in;
  // decode checks
  chk_cnt_sel: assert property (t && o == 8'hce |=> dr_sel_out == SBOD_DR_COUNTER)
    else $error("bad");
  chk_id_sel: assert property (t && (o == 8'h0f || o == 8'h90) |=>
    dr_sel_out == SBOD_DR_IDCODE) else $error("bad");
  chk_def_bypass: assert property (t && o == 8'h07 |=> dr_sel_out == SBOD_DR_BYPASS)
    else $error("bad");
  chk_pass_idx: assert property (t && o[7:3] == 5'h14 |=>
    dr_sel_out == SBOD_DR_PASS_EN && dr_index_out == $past(o[2:0])) else $error("bad");
  chk_dedio_idx: assert property (t && o[7:2] == 6'h2c |=>
    dr_sel_out == SBOD_DR_DED_IO && dr_index_out == {1'b0, $past(o[1:0])}) else $error("bad");
  chk_insert_on: assert property (bridge_sel_in |=> scan_insert_out)
    else $error("bad");
  chk_insert_off: assert property (!bridge_sel_in |=> !scan_insert_out)
    else $error("bad");
endmodule
bind sbod_decode sbod_decode_monitor mon (.tck_in, .rst_n_in, .ir_opcode_in, .ir_update_in,
  .tap_reset_in, .bridge_sel_in, .dr_sel_out, .dr_index_out, .scan_insert_out);

// File: testbench/sbod_tap_model.sv
module sbod_tap_model (
  // test clock
  input wire logic tck_in,
  // instruction and state lines
  output logic [7:0] op_out,
  output logic upd_out,
  output logic tr_out,
  output logic sel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {op_out, upd_out, tr_out, sel_out} = '0;
  // one load, update pulse one tck long
  task automatic load(input logic [7:0] op, input logic r, s);
    @(posedge tck_in);
    {op_out, upd_out, tr_out, sel_out} <= {op, 1'b1, r, s};
    @(posedge tck_in);
    {op_out, upd_out} <= {~op, 1'b0}; // released lines show garbage
  endtask
endmodule

// File: testbench/sbod_decode_tb_top.sv
module sbod_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, tck = 0, rst_n = 0, byp = 0, run = 0, upd, tr, bs, ins, cr, crs, dbs;
  logic [7:0] op;
  logic [4:0] sel;
  logic [2:0] idx;
  logic [31:0] rs = 32'h658c651d;
  int bad_count = 0, comparisons = 0, cyc = 0;
  // clocks, rising edges of the two never coincide
  always #25 mclk = ~mclk;
  always #6 tck = ~tck;
  sbod_tap_model tap (.tck_in(tck), .op_out(op), .upd_out(upd), .tr_out(tr), .sel_out(bs));
  sbod_decode uut (.mclk_in(mclk), .rst_n_in(rst_n), .tck_in(tck), .ir_opcode_in(op),
    .ir_update_in(upd), .tap_reset_in(tr), .bridge_sel_in(bs), .dr_sel_out(sel),
    .dr_index_out(idx), .scan_insert_out(ins), .counter_run_out(cr),
    .counter_run_sys_out(crs), .default_bypass_sys_out(dbs));
  // random source and expected decode
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] exp_dec(input logic [7:0] o, input logic r, b);
    if (r) return 8'h08;
    if (o == 8'hce) return 8'h20;
    if (o == 8'h07) return 8'h10;
    if (o == 8'h0f || o == 8'h90) return 8'h08;
    if (o[7:3] == 5'h14) return {5'h08, o[2:0]};
    if (o[7:2] == 6'h2c) return {6'h20, o[1:0]};
    return b ? 8'h10 : 8'h08;
  endfunction
  // selected register and index
  task automatic cmp_dec(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t sel/idx got %h exp %h", $time, g, e);
    end
  endtask
  // one-bit level pairs
  task automatic cmp_lvl(input logic [1:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t levels got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input logic [7:0] o, input logic r, s);
    tap.load(o, r, s);
    #1;
    byp = r ? 1'b0 : (byp | (o == 8'h07));
    run = (!r && o == 8'h0f) ? 1'b1 : (!r && o == 8'h90) ? 1'b0 : run;
    cmp_dec({sel, idx}, exp_dec(o, r, byp));
    cmp_lvl({ins, cr}, {s, run});
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      final_report;
    end
  end
  // directed corners, then random opcodes with tap resets
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    repeat (2) @(posedge mclk);
    cmp_dec({sel, idx}, 8'h08);
    cmp_lvl({ins, cr}, 2'h0);
    step(8'hce, 0, 1);
    step(8'h0f, 0, 0);
    for (int i = 0; i < 13; i++) step(8'ha0 + 8'(i < 8 ? i : i + 8), 0, i[0]);
    step(8'h07, 0, 0);
    step(8'h55, 0, 1);
    step(8'hce, 1, 0);
    step(8'h90, 0, 1);
    $display("test directed done");
    repeat (60) begin
      rs = xs(rs);
      step(rs[7:0], rs[8] & rs[9], rs[10]);
    end
    repeat (4) @(posedge mclk);
    cmp_lvl({crs, dbs}, {run, byp});
    $display("test random done");
    final_report;
  end
endmodule
